// >>> conv_if.sv
// Handshake between the register bank and the conversion sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface conv_if;
  import supervisor_bank_pkg::*;
  logic start;
  logic clear;
  logic done;
  logic [RESULT_W-1:0] result;
  modport bank(output start, output clear, input done, input result);
  modport engine(input start, input clear, output done, output result);
endinterface

// >>> conversion_sequencer.sv
// Single-shot conversion timer and result holder.
// Assumes the analog sample input is settled when the timer expires.
`timescale 1ns/100ps
module conversion_sequencer #(
  parameter int CONV_CYCLES = 4000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [supervisor_bank_pkg::RESULT_W-1:0] sample_in,
  conv_if.engine link
);
  import supervisor_bank_pkg::*;
  localparam int CW = $clog2(CONV_CYCLES + 1);
  typedef logic [CW-1:0] cnt_t;
  typedef struct packed {
    logic busy;
    logic done;
    cnt_t cnt;
    logic [RESULT_W-1:0] result;
  } conv_s;
  conv_s q;
  conv_s n;

  always_comb begin
    n = q;
    if (link.start) begin
      // Restart drops the running count, so only the last request completes
      n.busy = 1'b1;
      n.done = 1'b0;
      n.cnt = '0;
    end else if (q.busy) begin
      if (q.cnt == cnt_t'(CONV_CYCLES - 1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.result = sample_in;
      end else begin
        n.cnt = q.cnt + cnt_t'(1);
      end
    end
    if (link.clear || !rst_n_in) begin
      n.busy = 1'b0;
      n.done = 1'b1;
      n.cnt = '0;
      n.result = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    q <= n;
  end

  assign link.done = q.done;
  assign link.result = q.result;

  // ************************************************
  // Checks
  // ************************************************
  cnt_t since_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || link.start) begin
      since_q <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + cnt_t'(1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  done_delay_a: assert property ($rose(q.done) && !$past(link.clear) |-> since_q == cnt_t'(CONV_CYCLES))
    else $error("completion not exactly one conversion after last start");
  start_clear_a: assert property (link.start && !link.clear |=> !q.done && q.busy)
    else $error("completion flag not cleared by start");
  restart_cv: cover property (link.start ##[1:20] link.start);
  finish_cv: cover property ($rose(q.done));
endmodule

// >>> serial_master_model.sv
// Behavioural two-wire bus master for the supervisor register bank.
// Assumes SDA has a pull-up and that each task is entered at a falling clk_in edge.
`timescale 1ns/100ps
module serial_master_model (
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic pull_low;
  logic ack_ok;
  // Released wire floats high through the pull-up
  assign sda_out = !(sda_oe_in | pull_low);
  initial begin
    scl_out = 1'b1;
    pull_low = 1'b0;
    ack_ok = 1'b1;
  end
  // Data moves 25 ns after the fall, so it never races the clock edge
  task automatic bit_io(input logic b, output logic r);
    #25 pull_low = !b;
    #75 scl_out = 1'b1;
    #95 r = sda_out;
    #5 scl_out = 1'b0;
  endtask
  task automatic start_cond();
    pull_low = 1'b0;
    #100 scl_out = 1'b1;
    #100 pull_low = 1'b1;
    #100 scl_out = 1'b0;
  endtask
  task automatic stop_cond();
    #25 pull_low = 1'b1;
    #75 scl_out = 1'b1;
    #100 pull_low = 1'b0;
    #100;
  endtask
  task automatic send(input logic [7:0] tx);
    logic [7:0] rx;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    ack_ok = ack_ok & !a;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
    ack_ok = 1'b1;
    start_cond();
    send({dev, 1'b0});
    send(ofs);
    send(d);
    stop_cond();
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    ack_ok = 1'b1;
    start_cond();
    send({dev, 1'b0});
    send(ofs);
    stop_cond();
    start_cond();
    send({dev, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    // Nack ends the read after one byte
    bit_io(1'b1, a);
    stop_cond();
  endtask
endmodule

// >>> supervisor_bank_pkg.sv
// Constants, field layouts and state codes for the supervisor register bank.
// Assumes one system clock at 40 MHz; serial pins and analog flags are asynchronous.
// Overview of operation
// - Seventeen byte registers on the serial port.
// - Test port reaches every register identically.
// - Non-functional bits always read as one.
// - Comparator pairs packed from bit zero.
// - Window mode puts window result in first flag.
// - Result low nibble, ones, completion flag.
// - Control register: range bit four, channel low.
// - Range zero small scale, one large.
// - Channel codes route monitors and supply pins.
// - Control write latches fields, starts conversion.
// - Flag low while converting, high when done.
// - Restart delays flag until second conversion ends.
// - Pin levels in low nibble, ones above.
// - Selected inputs take override, others take pins.
// - Override bits three to one, cleared.
// - Any write to reset register resets device.
// - Write is address, offset, data, each acknowledged.
// - Read is offset write then one data byte, resent until master nack.
package supervisor_bank_pkg;
  localparam int REG_COUNT = 17;
  localparam logic [7:0] OFS_CMP_A = 8'h00;
  localparam logic [7:0] OFS_CMP_B = 8'h01;
  localparam logic [7:0] OFS_CMP_C = 8'h02;
  localparam logic [7:0] OFS_OUT_LO = 8'h03;
  localparam logic [7:0] OFS_OUT_HI = 8'h04;
  localparam logic [7:0] OFS_PINS = 8'h06;
  localparam logic [7:0] OFS_RES_LO = 8'h07;
  localparam logic [7:0] OFS_RES_HI = 8'h08;
  localparam logic [7:0] OFS_CONV = 8'h09;
  localparam logic [7:0] OFS_SIG0 = 8'h0a;
  localparam logic [7:0] OFS_SIG1 = 8'h0b;
  localparam logic [7:0] OFS_SIG2 = 8'h0c;
  localparam logic [7:0] OFS_SIG3 = 8'h0d;
  localparam logic [7:0] OFS_GP_LO = 8'h0e;
  localparam logic [7:0] OFS_GP_HI = 8'h0f;
  localparam logic [7:0] OFS_OVR = 8'h11;
  localparam logic [7:0] OFS_RST = 8'h12;
  localparam logic [7:0] FILL_ONES = 8'hff;
  localparam logic [7:0] GP_LO_RESET = 8'h04;
  localparam logic [5:0] GP_HI_RESET = 6'h00;
  localparam logic [2:0] OVR_RESET = 3'h0;
  localparam logic [4:0] CONV_RESET = 5'h00;
  localparam int RANGE_BIT = 4;
  localparam int CHAN_W = 4;
  localparam int RESULT_W = 12;
  localparam int MON_COUNT = 10;
  localparam int PIN_COUNT = 4;
  localparam int OUT_COUNT = 14;
  localparam int GP_HI_W = 6;
  localparam int OVR_W = 3;
  localparam int CLK_MHZ = 40;
  localparam int NS_PER_US = 1000;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_MACK = 4'h8,
    ST_HOLD = 4'h9
  } link_state_e;
endpackage

// >>> supervisor_serial_register_bank.sv
// Serial slave register bank of the supply supervisor with a parallel test port.
// Assumes open-drain pins resolved outside and test port logic on clk_in.
`timescale 1ns/100ps
module supervisor_serial_register_bank #(
  parameter int CONV_TIME_NS = 100000,
  parameter logic [31:0] SIGNATURE = 32'h5a3c_96e1 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [6:0] slave_address_in,
  input wire logic test_wr_in,
  input wire logic test_rd_in,
  input wire logic [7:0] test_addr_in,
  input wire logic [7:0] test_wdata_in,
  output logic [7:0] test_rdata_out,
  input wire logic [supervisor_bank_pkg::MON_COUNT-1:0] first_cmp_in,
  input wire logic [supervisor_bank_pkg::MON_COUNT-1:0] second_cmp_in,
  input wire logic [supervisor_bank_pkg::MON_COUNT-1:0] window_cmp_in,
  input wire logic [supervisor_bank_pkg::MON_COUNT-1:0] window_mode_in,
  input wire logic [supervisor_bank_pkg::PIN_COUNT-1:0] digital_input_pin_in,
  input wire logic [supervisor_bank_pkg::OVR_W-1:0] override_select_in,
  input wire logic [supervisor_bank_pkg::OUT_COUNT-1:0] output_drive_state_in,
  input wire logic [supervisor_bank_pkg::RESULT_W-1:0] conv_sample_in,
  output logic [supervisor_bank_pkg::PIN_COUNT-1:0] logic_array_input_out,
  output logic [7:0] general_drive_lo_out,
  output logic [supervisor_bank_pkg::GP_HI_W-1:0] general_drive_hi_out,
  output logic range_select_out,
  output logic [supervisor_bank_pkg::CHAN_W-1:0] channel_select_out,
  output logic device_reset_out
);
  import supervisor_bank_pkg::*;

  // ************************************************
  // Constants and state
  // ************************************************
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int A_LO = 0;
  localparam int B_LO = MON_COUNT;
  localparam int W_LO = 2 * MON_COUNT;
  localparam int P_LO = 3 * MON_COUNT;
  localparam int SDA_I = P_LO + PIN_COUNT;
  localparam int SCL_I = SDA_I + 1;
  localparam int SYNC_W = SCL_I + 1;

  typedef logic [SYNC_W-1:0] sync_t;
  typedef struct packed {
    sync_t s1;
    sync_t s2;
    sync_t s3;
    sync_t st;
    link_state_e state;
    logic [2:0] cnt;
    logic byte_full;
    logic rw;
    logic mack;
    logic [7:0] shift;
    logic [7:0] offset;
    logic sda_oe;
    logic [4:0] conv;
    logic [7:0] gp_lo;
    logic [GP_HI_W-1:0] gp_hi;
    logic [OVR_W-1:0] ovr;
    logic [7:0] test_rdata;
    logic [PIN_COUNT-1:0] la_in;
    logic soft_rst;
  } bank_s;

  bank_s q;
  bank_s n;
  conv_if link();

  logic [2*MON_COUNT-1:0] flags;
  logic [PIN_COUNT-1:0] la_d;
  logic [MON_COUNT-1:0] first_eff;
  logic wr_en;
  logic [7:0] wr_ofs;
  logic [7:0] wr_dat;
  logic [7:0] rd_link;
  sync_t st_n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sda_v;

  // ************************************************
  // Per-bit flag and input routing
  // ************************************************
  genvar gi;
  generate
    for (gi = 0; gi < MON_COUNT; gi++) begin : g_mon
      assign first_eff[gi] = window_mode_in[gi] ? q.st[W_LO+gi] : q.st[A_LO+gi];
      assign flags[2*gi] = first_eff[gi];
      assign flags[2*gi+1] = q.st[B_LO+gi];
    end
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      if (gi == 0) begin : g_fixed
        assign la_d[gi] = q.st[P_LO+gi];
      end else begin : g_sel
        assign la_d[gi] = override_select_in[gi-1] ? q.ovr[gi-1] : q.st[P_LO+gi];
      end
    end
  endgenerate

  // ************************************************
  // Read decode
  // ************************************************
  // Unmapped and write-only offsets read as all ones, like non-functional bits
  function automatic logic [7:0] rd_byte(input logic [7:0] ofs);
    logic [7:0] r;
    r = FILL_ONES;
    if (ofs == OFS_CMP_A) begin
      r = flags[7:0];
    end else if (ofs == OFS_CMP_B) begin
      r = flags[15:8];
    end else if (ofs == OFS_CMP_C) begin
      r = {FILL_ONES[7:4], flags[19:16]};
    end else if (ofs == OFS_OUT_LO) begin
      r = output_drive_state_in[7:0];
    end else if (ofs == OFS_OUT_HI) begin
      r = {FILL_ONES[7:6], output_drive_state_in[13:8]};
    end else if (ofs == OFS_PINS) begin
      r = {FILL_ONES[7:4], q.st[P_LO+:PIN_COUNT]};
    end else if (ofs == OFS_RES_LO) begin
      r = {link.result[3:0], FILL_ONES[3:1], link.done};
    end else if (ofs == OFS_RES_HI) begin
      r = link.result[RESULT_W-1:4];
    end else if (ofs == OFS_CONV) begin
      r = {FILL_ONES[7:5], q.conv};
    end else if (ofs == OFS_SIG0) begin
      r = SIGNATURE[7:0];
    end else if (ofs == OFS_SIG1) begin
      r = SIGNATURE[15:8];
    end else if (ofs == OFS_SIG2) begin
      r = SIGNATURE[23:16];
    end else if (ofs == OFS_SIG3) begin
      r = SIGNATURE[31:24];
    end else if (ofs == OFS_GP_LO) begin
      r = q.gp_lo;
    end else if (ofs == OFS_GP_HI) begin
      r = {FILL_ONES[7:6], q.gp_hi};
    end else if (ofs == OFS_OVR) begin
      r = {FILL_ONES[7:4], q.ovr, FILL_ONES[0]};
    end
    return r;
  endfunction

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    n = q;
    wr_en = 1'b0;
    wr_ofs = q.offset;
    wr_dat = q.shift;
    link.start = 1'b0;
    rd_link = rd_byte(q.offset);
    // Three stages; a level counts once stages two and three agree
    n.s1 = {scl_in, sda_in, digital_input_pin_in, window_cmp_in, second_cmp_in, first_cmp_in};
    n.s2 = q.s1;
    n.s3 = q.s2;
    st_n = (q.st & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
    n.st = st_n;
    sda_v = st_n[SDA_I];
    rise = !q.st[SCL_I] && st_n[SCL_I];
    fall = q.st[SCL_I] && !st_n[SCL_I];
    start = q.st[SCL_I] && st_n[SCL_I] && q.st[SDA_I] && !sda_v;
    stop = q.st[SCL_I] && st_n[SCL_I] && !q.st[SDA_I] && sda_v;
    n.la_in = la_d;
    n.soft_rst = 1'b0;
    if (test_rd_in) begin
      n.test_rdata = rd_byte(test_addr_in);
    end

    // Serial engine; a repeated start may arrive in any state
    if (start) begin
      n.state = ST_ADDR;
      n.cnt = 3'h0;
      n.byte_full = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.state = ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (q.state)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (rise) begin
            n.shift = {q.shift[6:0], sda_v};
            n.cnt = q.cnt + 3'h1;
            n.byte_full = (q.cnt == BYTE_LAST);
          end else if (fall && q.byte_full) begin
            n.byte_full = 1'b0;
            n.cnt = 3'h0;
            if (q.state == ST_ADDR) begin
              if (q.shift[7:1] == slave_address_in) begin
                n.rw = q.shift[0];
                n.state = ST_ADDR_ACK;
                n.sda_oe = 1'b1;
              end else begin
                n.state = ST_HOLD;
              end
            end else if (q.state == ST_REG) begin
              n.offset = q.shift;
              n.state = ST_REG_ACK;
              n.sda_oe = 1'b1;
            end else begin
              wr_en = 1'b1;
              n.state = ST_DATA_ACK;
              n.sda_oe = 1'b1;
            end
          end
        end
        ST_ADDR_ACK, ST_MACK: begin
          if (rise && q.state == ST_MACK) begin
            n.mack = !sda_v;
          end else if (fall) begin
            if (q.state == ST_ADDR_ACK && !q.rw) begin
              n.state = ST_REG;
              n.sda_oe = 1'b0;
            end else if (q.state == ST_ADDR_ACK || q.mack) begin
              // Byte is sampled here and shifted out from the shadow
              n.state = ST_RDATA;
              n.shift = {rd_link[6:0], 1'b0};
              n.sda_oe = !rd_link[7];
              n.cnt = 3'h1;
            end else begin
              n.state = ST_HOLD;
              n.sda_oe = 1'b0;
            end
          end
        end
        ST_REG_ACK: begin
          if (fall) begin
            n.state = ST_WDATA;
            n.sda_oe = 1'b0;
          end
        end
        ST_DATA_ACK: begin
          // One data byte per write; further bytes go unanswered
          if (fall) begin
            n.state = ST_HOLD;
            n.sda_oe = 1'b0;
          end
        end
        ST_RDATA: begin
          if (fall) begin
            if (q.cnt == 3'h0) begin
              n.state = ST_MACK;
              n.mack = 1'b0;
              n.sda_oe = 1'b0;
            end else begin
              n.sda_oe = !q.shift[7];
              n.shift = {q.shift[6:0], 1'b0};
              n.cnt = q.cnt + 3'h1;
            end
          end
        end
        default: begin
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Serial write wins over a test write in the same cycle
    if (!wr_en && test_wr_in) begin
      wr_en = 1'b1;
      wr_ofs = test_addr_in;
      wr_dat = test_wdata_in;
    end
    if (wr_en) begin
      if (wr_ofs == OFS_CONV) begin
        n.conv = wr_dat[4:0];
        link.start = 1'b1;
      end else if (wr_ofs == OFS_GP_LO) begin
        n.gp_lo = wr_dat;
      end else if (wr_ofs == OFS_GP_HI) begin
        n.gp_hi = wr_dat[GP_HI_W-1:0];
      end else if (wr_ofs == OFS_OVR) begin
        n.ovr = wr_dat[3:1];
      end else if (wr_ofs == OFS_RST) begin
        n.soft_rst = 1'b1;
      end
      // Other offsets are acknowledged and dropped
    end

    if (q.soft_rst) begin
      n.conv = CONV_RESET;
      n.gp_lo = GP_LO_RESET;
      n.gp_hi = GP_HI_RESET;
      n.ovr = OVR_RESET;
      link.start = 1'b0;
    end
    if (!rst_n_in) begin
      n = '0;
      n.state = ST_IDLE;
      n.gp_lo = GP_LO_RESET;
      n.gp_hi = GP_HI_RESET;
      n.ovr = OVR_RESET;
      n.conv = CONV_RESET;
      link.start = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    q <= n;
  end

  assign link.clear = q.soft_rst;

  conversion_sequencer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sample_in(conv_sample_in),
    .link(link)
  );

  // ************************************************
  // Outputs
  // ************************************************
  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_out = q.sda_oe;
  assign test_rdata_out = q.test_rdata;
  assign logic_array_input_out = q.la_in;
  assign general_drive_lo_out = q.gp_lo;
  assign general_drive_hi_out = q.gp_hi;
  assign range_select_out = q.conv[RANGE_BIT];
  assign channel_select_out = q.conv[CHAN_W-1:0];
  assign device_reset_out = q.soft_rst;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  conv_latch_a: assert property (wr_en && wr_ofs == OFS_CONV && !q.soft_rst |-> link.start ##1 q.conv == $past(wr_dat[4:0]))
    else $error("control write did not latch and start");
  ro_write_a: assert property (wr_en && wr_ofs <= OFS_RES_HI && !q.soft_rst |=> $stable(q.conv) && $stable(q.gp_lo) && $stable(q.gp_hi) && $stable(q.ovr))
    else $error("read-only write changed a register");
  reset_trig_a: assert property (wr_en && wr_ofs == OFS_RST |=> device_reset_out ##1 (!device_reset_out && general_drive_lo_out == GP_LO_RESET && general_drive_hi_out == GP_HI_RESET))
    else $error("reset register write did not reset");
  status_ones_a: assert property (test_rd_in && test_addr_in == OFS_CMP_C |=> test_rdata_out[7:4] == 4'hf)
    else $error("upper status bits not ones");
  result_lo_a: assert property (test_rd_in && test_addr_in == OFS_RES_LO |=> test_rdata_out[3:0] == {3'h7, $past(link.done)})
    else $error("result low byte layout wrong");
  window_flag_a: assert property (test_rd_in && test_addr_in == OFS_CMP_A |=> test_rdata_out[0] == ($past(window_mode_in[0]) ? $past(q.st[W_LO]) : $past(q.st[A_LO])))
    else $error("first flag ignores window mode");
  pin_read_a: assert property (test_rd_in && test_addr_in == OFS_PINS |=> test_rdata_out == {4'hf, $past(q.st[P_LO+:PIN_COUNT])})
    else $error("pin level register wrong");
  override_sel_a: assert property (1'b1 |=> logic_array_input_out[1] == ($past(override_select_in[0]) ? $past(q.ovr[0]) : $past(q.st[P_LO+1])))
    else $error("logic input source wrong");
  ack_drive_a: assert property (q.state inside {ST_REG_ACK, ST_DATA_ACK} |-> sda_oe_out && !sda_out)
    else $error("byte not acknowledged");
  master_ack_a: assert property (q.state == ST_MACK |-> !sda_oe_out)
    else $error("slave drove master acknowledge slot");
  write_cv: cover property (q.state == ST_DATA_ACK);
  read_cv: cover property (q.state == ST_MACK ##1 q.state == ST_HOLD);
  reset_cv: cover property (device_reset_out);
  done_cv: cover property ($rose(link.done));
endmodule

// >>> supervisor_serial_register_bank_tb.sv
// Self-checking bench for the supervisor register bank.
// Assumes the serial master model drives SCL and resolves SDA.
`timescale 1ns/100ps
module supervisor_serial_register_bank_tb;
  import supervisor_bank_pkg::*;
  typedef struct packed {logic [7:0] ofs; logic [7:0] val;} note_s;
  localparam logic [6:0] DEV = 7'h4b;
  localparam logic [31:0] SIG = 32'h1f2e_3d4c; // Arbitrary value
  logic clk_in = 0, rst_n_in = 0, scl, sda, sda_oe, test_wr = 0, test_rd = 0, rd_seen = 0;
  logic [7:0] test_addr = 0, test_wdata = 0, test_rdata, gp_lo, rd_val;
  logic [9:0] cmp_a = 0, cmp_b = 0, win = 0, wmode = 0;
  logic [3:0] pins = 0, la_in, chan;
  logic [2:0] osel = 0, ovr;
  logic [13:0] drv = 0;
  logic [11:0] sample = 0;
  logic [5:0] gp_hi;
  logic [19:0] st;
  logic rng, dev_rst;
  logic [31:0] lfsr = 32'hd710e2c2;
  int bad_count = 0, cmp_count = 0, resets = 0;
  note_s notes[$];
  initial begin
    forever #12.5 clk_in = !clk_in;
  end
  // Short conversion: 500 ns is 20 cycles
  supervisor_serial_register_bank #(.CONV_TIME_NS(500), .SIGNATURE(SIG))
    u_supervisor_serial_register_bank (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_out(sda_oe), .slave_address_in(DEV), .test_wr_in(test_wr), .test_rd_in(test_rd),
    .test_addr_in(test_addr), .test_wdata_in(test_wdata), .test_rdata_out(test_rdata),
    .first_cmp_in(cmp_a), .second_cmp_in(cmp_b), .window_cmp_in(win),
    .window_mode_in(wmode), .digital_input_pin_in(pins), .override_select_in(osel),
    .output_drive_state_in(drv), .conv_sample_in(sample), .logic_array_input_out(la_in),
    .general_drive_lo_out(gp_lo), .general_drive_hi_out(gp_hi), .range_select_out(rng),
    .channel_select_out(chan), .device_reset_out(dev_rst));
  serial_master_model u_serial_master_model (.sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (exp !== got) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tp_write(input logic [7:0] ofs, input logic [7:0] d);
    @(negedge clk_in);
    test_wr = 1'b1;
    test_addr = ofs;
    test_wdata = d;
    @(negedge clk_in);
    test_wr = 1'b0;
  endtask
  task automatic tp_read(input logic [7:0] ofs, input logic [7:0] exp);
    @(negedge clk_in);
    test_rd = 1'b1;
    test_addr = ofs;
    notes.push_back({ofs, exp});
    @(negedge clk_in);
    test_rd = 1'b0;
  endtask
  // Read data lands one edge after the strobe; looked at mid-cycle
  always @(posedge clk_in) rd_seen <= test_rd;
  always @(negedge clk_in) begin
    if (rd_seen) begin
      check($sformatf("rdata %h", notes[0].ofs), notes[0].val, test_rdata);
      void'(notes.pop_front());
    end
  end
  always @(posedge clk_in) begin
    if (dev_rst === 1'b1) resets++;
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    tp_read(8'h0e, 8'h04);
    tp_read(8'h0f, 8'hc0);
    tp_read(8'h11, 8'hf1);
    tp_read(8'h09, 8'he0);
    tp_read(8'h07, 8'h0f);
    tp_write(8'h08, 8'h5a);
    tp_read(8'h08, 8'h00);
    tp_read(8'h05, 8'hff);
    tp_read(8'h10, 8'hff);
    for (int i = 0; i < 4; i++) begin
      tp_write(8'h0a + 8'(i), 8'h00);
      tp_read(8'h0a + 8'(i), SIG[8*i +: 8]);
    end
    repeat (3) begin
      rd_val = 8'(rnd());
      ovr = rd_val[3:1];
      tp_write(8'h11, rd_val);
      tp_read(8'h11, {4'hf, ovr, 1'b1});
      tp_write(8'h0e, rd_val);
      tp_read(8'h0e, rd_val);
      tp_write(8'h0f, ~rd_val);
      tp_read(8'h0f, {2'b11, ~rd_val[5:0]});
      check("general_drive_hi_out", 6'(~rd_val[5:0]), gp_hi);
      @(negedge clk_in);
      {cmp_b, win, wmode} = 30'(rnd());
      {cmp_a, pins, osel, drv} = 31'(rnd());
      sample = 12'(rnd());
      repeat (8) @(negedge clk_in);
      for (int i = 0; i < 10; i++) {st[2*i+1], st[2*i]} = {cmp_b[i], wmode[i] ? win[i] : cmp_a[i]};
      tp_read(8'h00, st[7:0]);
      tp_read(8'h01, st[15:8]);
      tp_read(8'h02, {4'hf, st[19:16]});
      tp_read(8'h03, drv[7:0]);
      tp_read(8'h04, {2'b11, drv[13:8]});
      tp_read(8'h06, {4'hf, pins});
      check("logic_array_input_out", {osel[2] ? ovr[2] : pins[3], osel[1] ? ovr[1] : pins[2],
        osel[0] ? ovr[0] : pins[1], pins[0]}, la_in);
    end
    // Back-to-back writes keep restarting the conversion
    for (int c = 0; c < 14; c++) begin
      if (c < 10 || c > 11) begin
        rd_val = {3'b000, c[0], 4'(c)};
        tp_write(8'h09, rd_val);
        check("range and channel", rd_val[4:0], {rng, chan});
        tp_read(8'h09, rd_val | 8'he0);
      end
    end
    repeat (12) @(negedge clk_in);
    // No conversion has finished yet, so the result is still cleared
    tp_read(8'h07, 8'h0e);
    // Waits out the conversion time rather than trusting the flag
    repeat (10) @(negedge clk_in);
    tp_read(8'h07, {sample[3:0], 4'b1111});
    tp_read(8'h08, sample[11:4]);
    u_serial_master_model.write_reg(DEV, 8'h0e, 8'ha5);
    check("write ack", 1'b1, u_serial_master_model.ack_ok);
    check("general_drive_lo_out", 8'ha5, gp_lo);
    u_serial_master_model.read_reg(DEV, 8'h0b, rd_val);
    check("read ack", 1'b1, u_serial_master_model.ack_ok);
    check("serial read", SIG[15:8], rd_val);
    u_serial_master_model.write_reg(DEV ^ 7'h01, 8'h0e, 8'h3c);
    check("foreign address ack", 1'b0, u_serial_master_model.ack_ok);
    tp_read(8'h0e, 8'ha5);
    tp_write(8'h12, 8'h3c);
    repeat (2) @(negedge clk_in);
    check("device_reset_out pulses", 16'd1, 16'(resets));
    tp_read(8'h0e, 8'h04);
    tp_read(8'h11, 8'hf1);
    tp_read(8'h09, 8'he0);
    repeat (2) @(negedge clk_in);
    end_of_test();
  end
endmodule
